// >>> common/sensor_params.svh
// Register indices, field positions, reset values and strobe timing counts.
// Assumes a 32-bit bus with one register per word: byte address = 4 * index.
`ifndef SENSOR_PARAMS_SVH
`define SENSOR_PARAMS_SVH

`define IDX_RUN_CTRL 8'h0D
`define IDX_EDGE_CTRL 8'h1F
`define IDX_ACTIVE_ROWS 8'h40
`define IDX_ROW_WIDTH 8'h41
`define IDX_HBLANK 8'h42
`define IDX_VBLANK 8'h43
`define IDX_INTEG_ROWS 8'h44
`define IDX_STATUS 8'h45

`define BIT_SOFT_RESET 0
`define BIT_RESTART 1
`define BIT_STANDBY 2
`define BIT_FALL_EN 15
`define FALL_N_MSB 14
`define FALL_N_LSB 8
`define BIT_RISE_EN 7
`define RISE_N_MSB 6
`define RISE_N_LSB 0

`define DEF_RUN_CTRL 16'h0000
`define DEF_EDGE_CTRL 16'h0000
`define DEF_ACTIVE_ROWS 16'h0008
`define DEF_ROW_WIDTH 16'h0020
`define DEF_HBLANK 16'h0010
`define DEF_VBLANK 16'h0004
`define DEF_INTEG_ROWS 16'h0002

// Pixel clocks between frame strobe and row strobe edges in default mode
`define STROBE_LEAD_CLKS 6
// Extra pixel clocks added to the early edge leads in early fall and early rise modes
`define EARLY_EDGE_CONST 3

`endif

// >>> common/sensor_pkg.sv
// Types shared by the frame strobe logic.
// Assumes nothing beyond a SystemVerilog compiler.
package sensor_pkg;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SOFT,
        ST_STANDBY,
        ST_INTEG
    } run_state_t;

    typedef struct packed {
        logic fv;
        logic lv;
        logic [9:0] data;
    } pix_port_t;

    typedef struct packed {
        logic [15:0] active_rows;
        logic [15:0] row_width;
        logic [15:0] hblank;
        logic [15:0] vblank;
        logic [15:0] integ_rows;
    } geom_t;

endpackage

// >>> rtl/frame_strobe_gen.sv
// Sensor run control and frame/row strobe timing behind a Wishbone slave.
// Assumes a classic Wishbone master on clk_i and a free pixel clock pin.
// How it works
// - Standby bit set puts the core in low power until it is cleared.
// - Restart write cuts the current frame and restarts at the first row.
// - After restart, first frame waits for the programmed integration time.
// - Restart acts only on a written one and always reads zero.
// - Soft reset cuts the frame and drives the pixel port idle.
// - Soft reset returns all other registers to defaults; its bit stays.
// - Clearing soft reset resumes normal frame generation.
// - Default mode: frame strobe falls 6 clocks after last row strobe.
// - Early fall mode still produces the row strobe for every active row.
// - Early fall leads the last row end by (1+N) rows plus 3.
// - Default mode: frame strobe rises 6 clocks before first row strobe.
// - Early rise enable uses the 7-bit rise count instead of 6 clocks.
// - Early rise leads by (1+N) rows plus horizontal blank plus 3.
`include "sensor_params.svh"

module frame_strobe_gen
    import sensor_pkg::*;
#(
    parameter int POS_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pix_clk_i,
    output pix_port_t pix_o,
    output logic low_power_o
);

    localparam geom_t GEOM_DEF = '{`DEF_ACTIVE_ROWS, `DEF_ROW_WIDTH,
        `DEF_HBLANK, `DEF_VBLANK, `DEF_INTEG_ROWS};

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res;
    endfunction

    // Products are cut to the position width; geometry must fit in it
    function automatic logic [POS_W-1:0] rows_to_clks(input logic [15:0] n,
                                                      input logic [15:0] rt);
        logic [31:0] p;
        p = n * rt;
        return p[POS_W-1:0];
    endfunction

    logic pe;
    logic ack_r;
    logic [31:0] rd_r;
    logic soft_r;
    logic standby_r;
    logic [15:0] edge_r;
    geom_t geom_r;
    run_state_t state_r;
    logic [POS_W-1:0] wait_r;
    logic [POS_W-1:0] pos_r;
    logic [15:0] col_r;
    logic [15:0] row_r;
    logic frame_on_r;
    logic fv_r;
    logic lv_r;
    logic [9:0] data_r;

    logic [7:0] idx;
    logic access;
    logic wr;
    logic restart_p;
    logic [15:0] run_wdat;
    logic [31:0] rd_c;
    logic [15:0] row_time;
    logic [POS_W-1:0] frame_len;
    logic [POS_W-1:0] p_end;
    logic [POS_W-1:0] fall_lead;
    logic [POS_W-1:0] rise_lead;
    logic [POS_W-1:0] fall_pos;
    logic [POS_W-1:0] rise_pos;
    logic [POS_W-1:0] integ_clks;
    logic fall_en;
    logic rise_en;
    logic lv_c;

    pix_clk_edge u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pix_clk_i(pix_clk_i),
        .rise_o(pe)
    );

    // Bus slave: every access is answered one cycle after it is seen
    assign idx = wb_adr_i[9:2];
    assign access = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = access & wb_we_i;
    assign run_wdat = merge16({13'h0000, standby_r, 1'b0, soft_r},
                              wb_dat_i, wb_sel_i);
    assign restart_p = wr && idx == `IDX_RUN_CTRL && wb_sel_i[0]
                       && wb_dat_i[`BIT_RESTART] && !soft_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    always_comb begin
        rd_c = 32'h0000_0000;
        case (idx)
            // Restart bit never stored, so it reads back as zero
            `IDX_RUN_CTRL: rd_c = {29'h0000_0000, standby_r, 1'b0,
                                   soft_r};
            `IDX_EDGE_CTRL: rd_c = {16'h0000, edge_r};
            `IDX_ACTIVE_ROWS: rd_c = {16'h0000, geom_r.active_rows};
            `IDX_ROW_WIDTH: rd_c = {16'h0000, geom_r.row_width};
            `IDX_HBLANK: rd_c = {16'h0000, geom_r.hblank};
            `IDX_VBLANK: rd_c = {16'h0000, geom_r.vblank};
            `IDX_INTEG_ROWS: rd_c = {16'h0000, geom_r.integ_rows};
            `IDX_STATUS: rd_c = {27'h0000_000, fv_r, lv_r, low_power_o,
                                 state_r};
            default: rd_c = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_r <= 32'h0000_0000;
        end else if (access && !wb_we_i) begin
            rd_r <= rd_c;
        end
    end

    // Soft reset bit itself survives; it is excluded from its own reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_r <= 1'b0;
        end else if (wr && idx == `IDX_RUN_CTRL) begin
            soft_r <= run_wdat[`BIT_SOFT_RESET];
        end
    end

    // Writes to the other registers are lost while soft reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_r) begin
            standby_r <= 1'b0;
            edge_r <= `DEF_EDGE_CTRL;
            geom_r <= GEOM_DEF;
        end else if (wr) begin
            case (idx)
                `IDX_RUN_CTRL: standby_r <= run_wdat[`BIT_STANDBY];
                `IDX_EDGE_CTRL: edge_r <= merge16(edge_r, wb_dat_i,
                                                  wb_sel_i);
                `IDX_ACTIVE_ROWS: geom_r.active_rows <=
                    merge16(geom_r.active_rows, wb_dat_i, wb_sel_i);
                `IDX_ROW_WIDTH: geom_r.row_width <=
                    merge16(geom_r.row_width, wb_dat_i, wb_sel_i);
                `IDX_HBLANK: geom_r.hblank <=
                    merge16(geom_r.hblank, wb_dat_i, wb_sel_i);
                `IDX_VBLANK: geom_r.vblank <=
                    merge16(geom_r.vblank, wb_dat_i, wb_sel_i);
                `IDX_INTEG_ROWS: geom_r.integ_rows <=
                    merge16(geom_r.integ_rows, wb_dat_i, wb_sel_i);
                default: standby_r <= standby_r;
            endcase
        end
    end

    // Frame geometry; positions count pixel clocks from the first row start
    assign fall_en = edge_r[`BIT_FALL_EN];
    assign rise_en = edge_r[`BIT_RISE_EN];
    assign row_time = 16'(geom_r.row_width + geom_r.hblank);
    assign frame_len = rows_to_clks(16'(geom_r.active_rows + geom_r.vblank),
                                    row_time);
    assign p_end = POS_W'(rows_to_clks(16'(geom_r.active_rows - 16'h0001),
                                       row_time) + geom_r.row_width);
    assign fall_lead = POS_W'(rows_to_clks(
        16'({9'h000, edge_r[`FALL_N_MSB:`FALL_N_LSB]} + 16'h0001), row_time)
        + `EARLY_EDGE_CONST);
    assign rise_lead = rise_en ? POS_W'(rows_to_clks(
        16'({9'h000, edge_r[`RISE_N_MSB:`RISE_N_LSB]} + 16'h0001), row_time)
        + geom_r.hblank + `EARLY_EDGE_CONST)
        : POS_W'(`STROBE_LEAD_CLKS);
    // Early fall count beyond the row width is left to software
    assign fall_pos = fall_en ? POS_W'(p_end - fall_lead)
                              : POS_W'(p_end + `STROBE_LEAD_CLKS);
    assign rise_pos = POS_W'(frame_len - rise_lead);
    assign integ_clks = rows_to_clks(geom_r.integ_rows, row_time);
    // Row strobe does not depend on the frame strobe mode
    assign lv_c = frame_on_r && row_r < geom_r.active_rows
                  && col_r < geom_r.row_width;

    // Run state: soft reset beats standby, standby beats restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_INTEG;
            wait_r <= '0;
        end else if (soft_r) begin
            state_r <= ST_SOFT;
        end else if (standby_r) begin
            state_r <= ST_STANDBY;
        end else if (restart_p || state_r == ST_SOFT
                     || state_r == ST_STANDBY) begin
            state_r <= ST_INTEG;
            wait_r <= integ_clks;
        end else if (state_r == ST_INTEG) begin
            if (wait_r == '0) begin
                state_r <= ST_RUN;
            end else if (pe) begin
                wait_r <= wait_r - 1'b1;
            end
        end
    end

    assign low_power_o = state_r == ST_STANDBY;

    // Frame timing; a cut frame drops both strobes at once
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_r || restart_p || state_r != ST_RUN) begin
            fv_r <= 1'b0;
            lv_r <= 1'b0;
            data_r <= 10'h000;
            frame_on_r <= 1'b0;
            pos_r <= rise_pos;
            col_r <= 16'h0000;
            row_r <= 16'h0000;
        end else if (pe) begin
            if (pos_r == rise_pos) begin
                fv_r <= 1'b1;
            end else if (pos_r == fall_pos) begin
                fv_r <= 1'b0;
            end
            lv_r <= lv_c;
            data_r <= lv_c ? col_r[9:0] : 10'h000;
            if (pos_r >= frame_len - 1'b1) begin
                pos_r <= '0;
                col_r <= 16'h0000;
                row_r <= 16'h0000;
                frame_on_r <= 1'b1;
            end else begin
                pos_r <= pos_r + 1'b1;
                if (col_r >= row_time - 16'h0001) begin
                    col_r <= 16'h0000;
                    row_r <= row_r + 16'h0001;
                end else begin
                    col_r <= col_r + 16'h0001;
                end
            end
        end
    end

    assign pix_o = '{fv: fv_r, lv: lv_r, data: data_r};

    // Helper: pixel clocks spent waiting out the integration time
    logic [POS_W-1:0] integ_pe_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_r != ST_INTEG || restart_p) begin
            integ_pe_r <= '0;
        end else if (pe && wait_r != '0) begin
            integ_pe_r <= integ_pe_r + 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_standby_enter;
        $rose(standby_r) && !soft_r |-> ##[1:2] low_power_o;
    endproperty
    a_standby_enter: assert property (p_standby_enter)
        else $error("standby bit did not reach low power");
    property p_standby_hold;
        low_power_o && standby_r && !soft_r |=> low_power_o;
    endproperty
    a_standby_hold: assert property (p_standby_hold)
        else $error("low power left while standby bit set");
    property p_restart_cut;
        restart_p && !standby_r |=> state_r == ST_INTEG && !pix_o.fv
                                    && !pix_o.lv;
    endproperty
    a_restart_cut: assert property (p_restart_cut)
        else $error("restart did not cut the frame");
    property p_integ_wait;
        state_r == ST_INTEG && wait_r == '0 && !soft_r && !standby_r
            && !restart_p && $stable(integ_clks) && $past(wait_r) != '0
            |-> integ_pe_r == integ_clks;
    endproperty
    a_integ_wait: assert property (p_integ_wait)
        else $error("integration wait length wrong");
    property p_restart_read;
        wb_ack_o && !wb_we_i && idx == `IDX_RUN_CTRL
            |-> wb_dat_o[`BIT_RESTART] == 1'b0;
    endproperty
    a_restart_read: assert property (p_restart_read)
        else $error("restart bit read back as one");
    property p_soft_idle;
        soft_r |=> pix_o == '0 && state_r == ST_SOFT;
    endproperty
    a_soft_idle: assert property (p_soft_idle)
        else $error("pixel port not idle in soft reset");
    property p_soft_defaults;
        soft_r |=> edge_r == `DEF_EDGE_CTRL && geom_r == GEOM_DEF
                   && !standby_r;
    endproperty
    a_soft_defaults: assert property (p_soft_defaults)
        else $error("register not at default during soft reset");
    property p_soft_release;
        $fell(soft_r) |-> state_r == ST_SOFT ##1 state_r == ST_INTEG;
    endproperty
    a_soft_release: assert property (p_soft_release)
        else $error("soft reset release did not resume");
    property p_fall_default;
        state_r == ST_RUN && pe && fv_r && !fall_en && !soft_r
            && !restart_p && pos_r == POS_W'(p_end + 6) |=> !fv_r;
    endproperty
    a_fall_default: assert property (p_fall_default)
        else $error("frame strobe fall not 6 clocks after row strobe");
    property p_lv_rows;
        state_r == ST_RUN && pe && lv_c && !soft_r && !restart_p
            |=> pix_o.lv;
    endproperty
    a_lv_rows: assert property (p_lv_rows)
        else $error("row strobe missing for an active row");
    property p_fall_early;
        state_r == ST_RUN && pe && fv_r && fall_en && !soft_r && !restart_p
            && pos_r + fall_lead == p_end |=> !fv_r;
    endproperty
    a_fall_early: assert property (p_fall_early)
        else $error("early frame strobe fall misplaced");
    property p_rise_default;
        state_r == ST_RUN && pe && !rise_en && !soft_r && !restart_p
            && pos_r + 6 == frame_len |=> fv_r;
    endproperty
    a_rise_default: assert property (p_rise_default)
        else $error("frame strobe rise not 6 clocks before row strobe");
    property p_fv_steady;
        state_r == ST_RUN && fv_r && !soft_r && !restart_p && !standby_r
            && !(pe && pos_r == fall_pos) |=> fv_r;
    endproperty
    a_fv_steady: assert property (p_fv_steady)
        else $error("frame strobe dropped mid frame");

    c_restart: cover property (restart_p ##[1:1000] $rose(pix_o.fv));
    c_early_fall: cover property (fall_en && $fell(pix_o.fv));
    c_soft: cover property ($fell(soft_r) ##[1:1000] $rose(pix_o.lv));
    c_standby: cover property ($fell(low_power_o));

endmodule // frame_strobe_gen

// >>> rtl/pix_clk_edge.sv
// Pixel clock sampler: brings the pixel clock pin into clk_i and marks edges.
// Assumes clk_i runs well above twice the pixel clock rate.
module pix_clk_edge (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pix_clk_i,
    output logic rise_o
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pix_clk_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // One-cycle enable per pixel clock, two cycles behind the pin
    assign rise_o = sync_r & ~last_r;

endmodule // pix_clk_edge

// >>> sim/pix_capture.sv
// Receiver model for the parallel pixel port: stamps strobe edges.
// Assumes the port is stable at each pixel clock rise.
module pix_capture
    import sensor_pkg::*;
(
    input wire logic pix_clk_i,
    input pix_port_t pix_i,
    output int frames_o = 0,
    output int lead_o = 0,
    output int tail_o = 0,
    output int rows_o = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    int t_r = 0;
    int t_fr = 0;
    int t_lr = 0;
    int t_lf = 0;
    int t_ff = 0;
    int rows_r = 0;
    logic fv_q = 1'b0;
    logic lv_q = 1'b0;
    logic seen_r = 1'b0;

    // Figures of one frame are published at the next frame start, since
    // the early fall lets row strobes run on after the frame strobe drops
    always @(posedge pix_clk_i) begin
        t_r <= t_r + 1;
        fv_q <= pix_i.fv;
        lv_q <= pix_i.lv;
        if (pix_i.lv && !lv_q) begin
            rows_r <= rows_r + 1;
            if (rows_r == 0) begin
                t_lr <= t_r;
            end
        end
        if (!pix_i.lv && lv_q) begin
            t_lf <= t_r;
        end
        if (!pix_i.fv && fv_q) begin
            t_ff <= t_r;
        end
        if (pix_i.fv && !fv_q) begin
            if (seen_r) begin
                lead_o <= t_lr - t_fr;
                tail_o <= t_ff - t_lf;
                rows_o <= rows_r;
                frames_o <= frames_o + 1;
            end
            seen_r <= 1'b1;
            t_fr <= t_r;
            rows_r <= 0;
        end
    end
endmodule // pix_capture

// >>> sim/sensor_run_control_frame_strobe_bench.sv
// Bench for the run control bits and frame strobe timing.
// Assumes the Wishbone slave answers with a one-cycle ack.
`include "sensor_params.svh"

module sensor_run_control_frame_strobe_bench;
    import sensor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic pix_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    pix_port_t pix_o;
    logic low_power_o;
    int frames, lead_m, tail_m, rows_m;
    int fail_count = 0;
    int num_checks = 0;
    int cyc_n = 0;
    int n;
    logic [15:0] edge_v [4] = '{16'h0000, 16'h8100, 16'h0081, 16'h8181};
    int lead_v [4] = '{6, 6, 23, 23};
    int tail_v [4] = '{6, -19, 6, -19};

    frame_strobe_gen u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pix_clk_i(pix_clk_i), .pix_o(pix_o),
        .low_power_o(low_power_o));

    pix_capture u_cap (
        .pix_clk_i(pix_clk_i), .pix_i(pix_o), .frames_o(frames),
        .lead_o(lead_m), .tail_o(tail_m), .rows_o(rows_m));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Odd start offset keeps the pixel clock unrelated in phase
    initial begin
        #13;
        forever #40 pix_clk_i = ~pix_clk_i;
    end

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        forever begin
            @(posedge clk_i);
            cyc_n++;
            if (cyc_n == 60000) begin
                fail_count++;
                final_report();
            end
        end
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(logic we, logic [7:0] idx, logic [15:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h3;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {16'h0000, wd};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(logic [7:0] idx, logic [15:0] wd);
        logic [31:0] rd;
        xfer(1'b1, idx, wd, rd);
    endtask

    task automatic rd_chk(string what, logic [7:0] idx, logic [15:0] exp);
        logic [31:0] rd;
        xfer(1'b0, idx, 16'h0000, rd);
        check(what, {16'h0000, exp}, rd);
    endtask

    // Judges the first whole frame, published at the second frame start, so that a frame cut by the last
    // register write is never measured
    task automatic frame_chk(int lead, int tail, int rows);
        int f0;
        f0 = frames;
        while (frames < f0 + 2) @(posedge clk_i);
        check("fv lead", lead, lead_m);
        check("fv tail", tail, tail_m);
        check("rows", rows, rows_m);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("run ctrl reset", `IDX_RUN_CTRL, 16'h0000);
        rd_chk("edge ctrl reset", `IDX_EDGE_CTRL, 16'h0000);
        rd_chk("rows reset", `IDX_ACTIVE_ROWS, 16'h0008);
        rd_chk("unmapped", 8'h50, 16'h0000);
        $display("Test reset done");

        wr(`IDX_ACTIVE_ROWS, 16'h0004);
        wr(`IDX_ROW_WIDTH, 16'h0004);
        wr(`IDX_HBLANK, 16'h0004);
        wr(`IDX_VBLANK, 16'h0004);
        wr(`IDX_INTEG_ROWS, 16'h0001);
        // Fall counts stay within the row width of 4
        for (int i = 0; i < 4; i++) begin
            wr(`IDX_EDGE_CTRL, edge_v[i]);
            rd_chk("edge ctrl", `IDX_EDGE_CTRL, edge_v[i]);
            frame_chk(lead_v[i], tail_v[i], 4);
        end
        wr(`IDX_EDGE_CTRL, 16'h0000);
        $display("Test strobe edges done");

        while (pix_o.fv !== 1'b1) @(posedge clk_i);
        wr(`IDX_RUN_CTRL, 16'h0002);
        @(posedge clk_i);
        check("restart cut", 32'h0, {20'h0_0000, pix_o});
        n = 0;
        while (pix_o.fv !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        check("restart wait", 32'h1, {31'h0, (n >= 56 && n <= 88)});
        rd_chk("restart reads 0", `IDX_RUN_CTRL, 16'h0000);
        frame_chk(6, 6, 4);
        $display("Test restart done");

        wr(`IDX_RUN_CTRL, 16'h0001);
        @(posedge clk_i);
        check("soft idle", 32'h0, {20'h0_0000, pix_o});
        rd_chk("soft bit kept", `IDX_RUN_CTRL, 16'h0001);
        rd_chk("rows default", `IDX_ACTIVE_ROWS, 16'h0008);
        rd_chk("width default", `IDX_ROW_WIDTH, 16'h0020);
        wr(`IDX_ACTIVE_ROWS, 16'h0004);
        rd_chk("rows held", `IDX_ACTIVE_ROWS, 16'h0008);
        wr(`IDX_RUN_CTRL, 16'h0000);
        frame_chk(6, 6, 8);
        $display("Test soft reset done");

        // Registers of the hang range are never touched in low power
        wr(`IDX_RUN_CTRL, 16'h0004);
        repeat (1000) @(posedge clk_i);
        check("low power", 32'h1, {31'h0, low_power_o});
        check("standby idle", 32'h0, {20'h0_0000, pix_o});
        rd_chk("status standby", `IDX_STATUS, 16'h0006);
        wr(`IDX_RUN_CTRL, 16'h0000);
        @(posedge clk_i);
        check("low power off", 32'h0, {31'h0, low_power_o});
        frame_chk(6, 6, 8);
        $display("Test standby done");
        final_report();
    end
endmodule // sensor_run_control_frame_strobe_bench
